// file: src/pwmpt_pkg.sv
package pwmpt_pkg;
    // widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 8;
    localparam int FINE_W = 2;
    localparam int DUTY_W = CNT_W + FINE_W;
    localparam int PSEL_W = 3;
    localparam int PRE_W  = 7;
    localparam int SUB_W  = FINE_W + PRE_W;
    localparam int ROUTE_W = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_TIMER_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PERIOD      = 4'h1;
    localparam logic [ADDR_W-1:0] REG_TIMER_COUNT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_MOD_CTRL    = 4'h3;
    localparam logic [ADDR_W-1:0] REG_DUTY_H      = 4'h4;
    localparam logic [ADDR_W-1:0] REG_DUTY_L      = 4'h5;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT    = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK    = 4'h7;
    localparam logic [ADDR_W-1:0] REG_PIN_DIR     = 4'h8;
    localparam logic [ADDR_W-1:0] REG_PIN_ROUTE   = 4'h9;
    localparam logic [ADDR_W-1:0] REG_PORT        = 4'hA;

    // field positions
    localparam int TCTRL_ON_BIT   = 7;
    localparam int TCTRL_PSEL_LSB = 0;
    localparam int MCTRL_EN_BIT   = 7;
    localparam int MCTRL_POL_BIT  = 4;
    localparam int DUTYL_LSB      = 6;
    localparam int IRQ_MATCH_BIT  = 0;
    localparam int PIN_BIT        = 0;
    localparam int ROUTE_LSB      = 0;

    // reset values and codes
    localparam logic [CNT_W-1:0]   PERIOD_RST = 8'hFF;
    localparam logic [CNT_W-1:0]   DUTY_H_RST = 8'h00;
    localparam logic [FINE_W-1:0]  DUTY_L_RST = 2'h0;
    localparam logic [PSEL_W-1:0]  PSEL_RST   = 3'h0;
    localparam logic [ROUTE_W-1:0] ROUTE_PORT = 3'h0;
    localparam logic [ROUTE_W-1:0] ROUTE_MOD  = 3'h1;
    localparam logic [DATA_W-1:0]  RD_ZERO    = 8'h00;

    // last sub-count before a timer tick: one less than four clocks times the prescale ratio
    function automatic logic [SUB_W-1:0] sub_last(input logic [PSEL_W-1:0] psel);
        sub_last = SUB_W'((1 << (FINE_W + int'(psel))) - 1);
    endfunction

    // two fine phase bits that extend the count to the duty width
    function automatic logic [FINE_W-1:0] ext_bits(input logic [SUB_W-1:0] sub,
                                                    input logic [PSEL_W-1:0] psel);
        logic [SUB_W-1:0] sh;
        sh = sub >> psel;
        ext_bits = sh[FINE_W-1:0];
    endfunction
endpackage

// file: src/pwmpt_timer.sv
`timescale 1ns/100ps
module pwmpt_timer (
    // clock and reset
    input  wire logic  CLK,
    input  wire logic  NRST,
    // control and count
    pwmpt_tmr_if.tmr   t
);
    localparam int CNT_W = pwmpt_pkg::CNT_W;
    localparam int SUB_W = pwmpt_pkg::SUB_W;

    logic [pwmpt_pkg::SUB_W-1:0] sub_r;
    logic [pwmpt_pkg::SUB_W-1:0] sub_nxt;
    logic [pwmpt_pkg::CNT_W-1:0] cnt_r;
    logic [pwmpt_pkg::CNT_W-1:0] cnt_nxt;
    logic                        match_r;
    logic                        match_nxt;
    logic                        tick;

    assign tick = t.on && !t.sleep && (sub_r >= pwmpt_pkg::sub_last(t.psel));

    always_comb begin
        sub_nxt   = sub_r;
        cnt_nxt   = cnt_r;
        match_nxt = 1'b0;
        // frozen while off or asleep; nothing is cleared on wake
        if (t.on && !t.sleep) begin
            if (tick) begin
                sub_nxt = '0;
                if (cnt_r == t.period) begin
                    cnt_nxt   = '0;
                    match_nxt = 1'b1;
                end else begin
                    cnt_nxt = CNT_W'(cnt_r + 1'b1);
                end
            end else begin
                sub_nxt = SUB_W'(sub_r + 1'b1);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sub_r   <= '0;
            cnt_r   <= '0;
            match_r <= 1'b0;
        end else begin
            sub_r   <= sub_nxt;
            cnt_r   <= cnt_nxt;
            match_r <= match_nxt;
        end
    end

    assign t.count = cnt_r;
    assign t.ext   = pwmpt_pkg::ext_bits(sub_r, t.psel);
    assign t.match = match_r;

    property p_sleep_freeze;
        @(posedge CLK) disable iff (!NRST)
        t.sleep |=> $stable(cnt_r) && $stable(sub_r) && !match_r;
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("timer moved during sleep");

    sequence s_wake;
        t.sleep ##1 (!t.sleep && t.on && cnt_r != t.period);
    endsequence
    property p_wake_resume;
        @(posedge CLK) disable iff (!NRST)
        s_wake |=> (cnt_r == $past(cnt_r)) || (cnt_r == CNT_W'($past(cnt_r) + 1'b1));
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("timer cleared on wake");

    sequence s_run4;
        (t.on && !t.sleep && t.psel == 3'h0 && t.period != 8'h00)[*4];
    endsequence
    property p_sysclk_rate;
        @(posedge CLK) disable iff (!NRST)
        s_run4 |=> cnt_r != $past(cnt_r, 4);
    endproperty
    a_sysclk_rate: assert property (p_sysclk_rate) else $error("timer not one step per four clocks");

    property p_off_hold;
        @(posedge CLK) disable iff (!NRST)
        !t.on |=> $stable(cnt_r) && !match_r;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("timer counted while off");

    property p_match_restart;
        @(posedge CLK) disable iff (!NRST)
        tick && cnt_r == t.period |=> match_r && cnt_r == 8'h00 ##1 !match_r;
    endproperty
    a_match_restart: assert property (p_match_restart) else $error("period match did not restart");
endmodule

// file: src/pwmpt_tmr_if.sv
`timescale 1ns/100ps
interface pwmpt_tmr_if;
    logic                           on;
    logic [pwmpt_pkg::PSEL_W-1:0]   psel;
    logic [pwmpt_pkg::CNT_W-1:0]    period;
    logic                           sleep;
    logic [pwmpt_pkg::CNT_W-1:0]    count;
    logic [pwmpt_pkg::FINE_W-1:0]   ext;
    logic                           match;

    modport tmr (input on, input psel, input period, input sleep,
                 output count, output ext, output match);
    modport ctl (output on, output psel, output period, output sleep,
                 input count, input ext, input match);
endinterface

// file: src/pwmpt_top.sv
`timescale 1ns/100ps
module pwmpt_top (
    // clock and reset
    input  wire logic                            CLK,
    input  wire logic                            NRST,
    // register port
    input  wire logic [pwmpt_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic [pwmpt_pkg::DATA_W-1:0]    WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output      logic [pwmpt_pkg::DATA_W-1:0]    RDATA,
    // power state
    input  wire logic                            SLEEP,
    // pin
    input  wire logic                            PIN_I,
    output      logic                            PIN_O,
    output      logic                            PIN_OE_N,
    // observation and interrupt
    output      logic                            MOD_OUT,
    output      logic                            IRQ
);
    localparam int DATA_W = pwmpt_pkg::DATA_W;
    localparam int DUTY_W = pwmpt_pkg::DUTY_W;

    pwmpt_tmr_if tif ();

    pwmpt_timer i_pwmpt_timer (
        .CLK  (CLK),
        .NRST (NRST),
        .t    (tif.tmr)
    );

    logic                               t_on_r;
    logic                               t_on_nxt;
    logic [pwmpt_pkg::PSEL_W-1:0]       t_psel_r;
    logic [pwmpt_pkg::PSEL_W-1:0]       t_psel_nxt;
    logic [pwmpt_pkg::CNT_W-1:0]        period_r;
    logic [pwmpt_pkg::CNT_W-1:0]        period_nxt;
    logic                               m_en_r;
    logic                               m_en_nxt;
    logic                               m_pol_r;
    logic                               m_pol_nxt;
    logic [pwmpt_pkg::CNT_W-1:0]        duty_h_r;
    logic [pwmpt_pkg::CNT_W-1:0]        duty_h_nxt;
    logic [pwmpt_pkg::FINE_W-1:0]       duty_l_r;
    logic [pwmpt_pkg::FINE_W-1:0]       duty_l_nxt;
    logic                               stat_r;
    logic                               stat_nxt;
    logic                               mask_r;
    logic                               mask_nxt;
    logic                               dir_r;
    logic                               dir_nxt;
    logic [pwmpt_pkg::ROUTE_W-1:0]      route_r;
    logic [pwmpt_pkg::ROUTE_W-1:0]      route_nxt;
    logic                               latch_r;
    logic                               latch_nxt;
    logic                               out_r;
    logic                               out_nxt;
    logic                               pin_do_r;
    logic                               pin_do_nxt;
    logic [DATA_W-1:0]                  rdata_r;
    logic [DATA_W-1:0]                  rdata_nxt;
    logic                               pin_meta_r;
    logic                               pin_sync_r;
    logic [DUTY_W-1:0]                  duty_value;
    logic [DUTY_W-1:0]                  phase;
    logic                               wave_raw;
    logic                               wr_ctrl;
    logic                               wr_mctl;

    assign tif.on     = t_on_r;
    assign tif.psel   = t_psel_r;
    assign tif.period = period_r;
    assign tif.sleep  = SLEEP;

    // duty and phase both ten bits wide; a short period simply never reaches the top codes
    assign duty_value = {duty_h_r, duty_l_r};
    assign phase      = {tif.count, tif.ext};
    assign wave_raw   = phase < duty_value;

    assign wr_ctrl = WR && ADDR == pwmpt_pkg::REG_TIMER_CTRL;
    assign wr_mctl = WR && ADDR == pwmpt_pkg::REG_MOD_CTRL;

    // register writes
    always_comb begin
        t_on_nxt   = t_on_r;
        t_psel_nxt = t_psel_r;
        period_nxt = period_r;
        m_en_nxt   = m_en_r;
        m_pol_nxt  = m_pol_r;
        duty_h_nxt = duty_h_r;
        duty_l_nxt = duty_l_r;
        mask_nxt   = mask_r;
        dir_nxt    = dir_r;
        route_nxt  = route_r;
        latch_nxt  = latch_r;
        if (wr_ctrl) begin
            t_on_nxt   = WDATA[pwmpt_pkg::TCTRL_ON_BIT];
            t_psel_nxt = WDATA[pwmpt_pkg::TCTRL_PSEL_LSB +: pwmpt_pkg::PSEL_W];
        end
        if (WR && ADDR == pwmpt_pkg::REG_PERIOD) begin
            period_nxt = WDATA;
        end
        if (wr_mctl) begin
            m_en_nxt  = WDATA[pwmpt_pkg::MCTRL_EN_BIT];
            m_pol_nxt = WDATA[pwmpt_pkg::MCTRL_POL_BIT];
        end
        if (WR && ADDR == pwmpt_pkg::REG_DUTY_H) begin
            duty_h_nxt = WDATA;
        end
        if (WR && ADDR == pwmpt_pkg::REG_DUTY_L) begin
            duty_l_nxt = WDATA[pwmpt_pkg::DUTYL_LSB +: pwmpt_pkg::FINE_W];
        end
        if (WR && ADDR == pwmpt_pkg::REG_IRQ_MASK) begin
            mask_nxt = WDATA[pwmpt_pkg::IRQ_MATCH_BIT];
        end
        if (WR && ADDR == pwmpt_pkg::REG_PIN_DIR) begin
            dir_nxt = WDATA[pwmpt_pkg::PIN_BIT];
        end
        if (WR && ADDR == pwmpt_pkg::REG_PIN_ROUTE) begin
            route_nxt = WDATA[pwmpt_pkg::ROUTE_LSB +: pwmpt_pkg::ROUTE_W];
        end
        if (WR && ADDR == pwmpt_pkg::REG_PORT) begin
            latch_nxt = WDATA[pwmpt_pkg::PIN_BIT];
        end
    end

    // sticky flag: a match in the clearing cycle survives the write-one-to-clear
    always_comb begin
        stat_nxt = stat_r;
        if (WR && ADDR == pwmpt_pkg::REG_IRQ_STAT && WDATA[pwmpt_pkg::IRQ_MATCH_BIT]) begin
            stat_nxt = 1'b0;
        end
        if (tif.match) begin
            stat_nxt = 1'b1;
        end
    end

    // waveform and pin; held as-is during sleep
    always_comb begin
        out_nxt    = out_r;
        pin_do_nxt = pin_do_r;
        if (!SLEEP) begin
            out_nxt    = m_en_r && (wave_raw ^ m_pol_r);
            pin_do_nxt = (route_r == pwmpt_pkg::ROUTE_MOD) ? out_nxt : latch_r;
        end
    end

    // read data valid only in the cycle after the strobe
    always_comb begin
        rdata_nxt = pwmpt_pkg::RD_ZERO;
        if (RD) begin
            unique case (ADDR)
                pwmpt_pkg::REG_TIMER_CTRL: begin
                    rdata_nxt[pwmpt_pkg::TCTRL_ON_BIT] = t_on_r;
                    rdata_nxt[pwmpt_pkg::TCTRL_PSEL_LSB +: pwmpt_pkg::PSEL_W] = t_psel_r;
                end
                pwmpt_pkg::REG_PERIOD:      rdata_nxt = period_r;
                pwmpt_pkg::REG_TIMER_COUNT: rdata_nxt = tif.count;
                pwmpt_pkg::REG_MOD_CTRL: begin
                    rdata_nxt[pwmpt_pkg::MCTRL_EN_BIT]  = m_en_r;
                    rdata_nxt[pwmpt_pkg::MCTRL_POL_BIT] = m_pol_r;
                end
                pwmpt_pkg::REG_DUTY_H:      rdata_nxt = duty_h_r;
                pwmpt_pkg::REG_DUTY_L: begin
                    rdata_nxt[pwmpt_pkg::DUTYL_LSB +: pwmpt_pkg::FINE_W] = duty_l_r;
                end
                pwmpt_pkg::REG_IRQ_STAT:    rdata_nxt[pwmpt_pkg::IRQ_MATCH_BIT] = stat_r;
                pwmpt_pkg::REG_IRQ_MASK:    rdata_nxt[pwmpt_pkg::IRQ_MATCH_BIT] = mask_r;
                pwmpt_pkg::REG_PIN_DIR:     rdata_nxt[pwmpt_pkg::PIN_BIT] = dir_r;
                pwmpt_pkg::REG_PIN_ROUTE:   rdata_nxt[pwmpt_pkg::ROUTE_LSB +: pwmpt_pkg::ROUTE_W] = route_r;
                pwmpt_pkg::REG_PORT:        rdata_nxt[pwmpt_pkg::PIN_BIT] = pin_sync_r;
                default:                    rdata_nxt = pwmpt_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            t_on_r   <= 1'b0;
            t_psel_r <= pwmpt_pkg::PSEL_RST;
            period_r <= pwmpt_pkg::PERIOD_RST;
            m_en_r   <= 1'b0;
            m_pol_r  <= 1'b0;
            duty_h_r <= pwmpt_pkg::DUTY_H_RST;
            duty_l_r <= pwmpt_pkg::DUTY_L_RST;
            stat_r   <= 1'b0;
            mask_r   <= 1'b0;
            dir_r    <= 1'b1;
            route_r  <= pwmpt_pkg::ROUTE_PORT;
            latch_r  <= 1'b0;
            out_r    <= 1'b0;
            pin_do_r <= 1'b0;
            rdata_r  <= pwmpt_pkg::RD_ZERO;
        end else begin
            t_on_r   <= t_on_nxt;
            t_psel_r <= t_psel_nxt;
            period_r <= period_nxt;
            m_en_r   <= m_en_nxt;
            m_pol_r  <= m_pol_nxt;
            duty_h_r <= duty_h_nxt;
            duty_l_r <= duty_l_nxt;
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            dir_r    <= dir_nxt;
            route_r  <= route_nxt;
            latch_r  <= latch_nxt;
            out_r    <= out_nxt;
            pin_do_r <= pin_do_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // pin input comes from outside the clock domain
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= PIN_I;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign RDATA    = rdata_r;
    assign PIN_O    = pin_do_r;
    assign PIN_OE_N = dir_r;
    assign MOD_OUT  = out_r;
    assign IRQ      = stat_r && mask_r;

    property p_sleep_pin;
        @(posedge CLK) disable iff (!NRST)
        SLEEP |=> $stable(PIN_O) && $stable(MOD_OUT) && $stable(PIN_OE_N);
    endproperty
    a_sleep_pin: assert property (p_sleep_pin) else $error("pin level changed in sleep");

    property p_reset_vals;
        @(posedge CLK)
        !NRST |=> PIN_OE_N && period_r == 8'hFF && !t_on_r && !m_en_r && !IRQ && !MOD_OUT;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong");

    sequence s_wr_dh;
        WR && ADDR == pwmpt_pkg::REG_DUTY_H;
    endsequence
    sequence s_rd_dh;
        RD && !WR && ADDR == pwmpt_pkg::REG_DUTY_H;
    endsequence
    property p_duty_h_rb;
        @(posedge CLK) disable iff (!NRST)
        s_wr_dh ##1 s_rd_dh |=> RDATA == $past(WDATA, 2);
    endproperty
    a_duty_h_rb: assert property (p_duty_h_rb) else $error("duty high readback wrong");

    property p_duty_l_zero;
        @(posedge CLK) disable iff (!NRST)
        RD && ADDR == pwmpt_pkg::REG_DUTY_L |=> RDATA[5:0] == 6'h00 && RDATA[7:6] == $past(duty_l_r);
    endproperty
    a_duty_l_zero: assert property (p_duty_l_zero) else $error("duty low layout wrong");

    property p_polarity;
        @(posedge CLK) disable iff (!NRST)
        !SLEEP && m_en_r |=> MOD_OUT == ($past(wave_raw) ^ $past(m_pol_r));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity not applied");

    property p_match_flag;
        @(posedge CLK) disable iff (!NRST)
        tif.match |=> stat_r ##1 (stat_r || $past(WR));
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("period flag not set");

    // a set flag only drops on a write of one to its bit
    property p_flag_sticky;
        @(posedge CLK) disable iff (!NRST)
        stat_r && !(WR && ADDR == pwmpt_pkg::REG_IRQ_STAT && WDATA[pwmpt_pkg::IRQ_MATCH_BIT]) |=> stat_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("period flag dropped on its own");

    property p_routed_pin;
        @(posedge CLK) disable iff (!NRST)
        !SLEEP && route_r == pwmpt_pkg::ROUTE_MOD |=> PIN_O == MOD_OUT;
    endproperty
    a_routed_pin: assert property (p_routed_pin) else $error("modulator not routed to pin");

    property p_dir_write;
        @(posedge CLK) disable iff (!NRST)
        WR && ADDR == pwmpt_pkg::REG_PIN_DIR |=> PIN_OE_N == $past(WDATA[pwmpt_pkg::PIN_BIT]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("pin direction write lost");
endmodule

// file: testbench/pwm_with_period_timer_tb.sv
`timescale 1ns/100ps
module pwm_with_period_timer_tb;
    localparam logic [7:0] RST_V [12] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
                                          8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    localparam logic [7:0] RES_P [3] = '{8'hFF, 8'h3F, 8'h1F};
    logic       clk      = 1'b0;
    logic       nrst     = 1'b0;
    logic [3:0] addr     = 4'h0;
    logic [7:0] wdata    = 8'h00;
    logic       wr       = 1'b0;
    logic       rd       = 1'b0;
    logic       sleep    = 1'b0;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [7:0] c0;
    logic [7:0] c1;
    logic       pin_i;
    logic       pin_o;
    logic       pin_oe_n;
    logic       mod_out;
    logic       irq;
    logic       m;
    logic       p;
    logic       held;
    logic [15:0] hi;
    logic [15:0] hp;
    logic [15:0] rise;
    int         n_fail   = 0;
    int         compares = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    pwmpt_top i_pwmpt_top (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SLEEP(sleep), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n),
        .MOD_OUT(mod_out), .IRQ(irq));
    pwmpt_load i_pwmpt_load (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_lvl(pin_i));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        #1 q = rdata;
    endtask

    // sleep for n+6 cycles; pin is checked over n of them, count is sampled around them
    task automatic nap(input int n);
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        #1 m = mod_out;
        p    = pin_o;
        held = 1'b1;
        rd_reg(pwmpt_pkg::REG_TIMER_COUNT, c0);
        repeat (n) begin
            @(posedge clk);
            #1 held = held & (mod_out === m) & (pin_o === p);
        end
        rd_reg(pwmpt_pkg::REG_TIMER_COUNT, c1);
        @(posedge clk);
        sleep <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        rd_reg(a, rv);
        chk({8'h00, rv}, {8'h00, exp});
    endtask

    task automatic measure(input int n);
        logic q;
        hi   = 16'h0000;
        hp   = 16'h0000;
        rise = 16'h0000;
        @(posedge clk);
        #1 q = mod_out;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (mod_out === 1'b1) hi++;
            if (pin_i === 1'b1) hp++;
            if (mod_out === 1'b1 && q === 1'b0) rise++;
            q = mod_out;
        end
    endtask

    task automatic wait_irq;
        for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk);
        #1;
    endtask

    task automatic results;
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        #1 chk({15'h0000, pin_oe_n}, 16'h0001);
        for (int i = 0; i < 12; i++) rd_chk(4'(i), RST_V[i]);
        wr_rd(pwmpt_pkg::REG_DUTY_H, 8'hA5, rv);
        chk({8'h00, rv}, 16'h00A5);
        wr_reg(pwmpt_pkg::REG_DUTY_L, 8'hFF);
        rd_chk(pwmpt_pkg::REG_DUTY_L, 8'hC0);
        wr_reg(pwmpt_pkg::REG_TIMER_COUNT, 8'h55);
        rd_chk(pwmpt_pkg::REG_TIMER_COUNT, 8'h00);
        wr_reg(4'hC, 8'hFF);
        rd_chk(4'hC, 8'h00);
        // full-first-period bring-up order, duty 6 of a 16-clock period
        wr_reg(pwmpt_pkg::REG_PIN_DIR, 8'h01);
        wr_reg(pwmpt_pkg::REG_MOD_CTRL, 8'h00);
        wr_reg(pwmpt_pkg::REG_PERIOD, 8'h03);
        wr_reg(pwmpt_pkg::REG_DUTY_H, 8'h01);
        wr_reg(pwmpt_pkg::REG_DUTY_L, 8'h80);
        wr_reg(pwmpt_pkg::REG_IRQ_STAT, 8'h01);
        wr_reg(pwmpt_pkg::REG_IRQ_MASK, 8'h01);
        wr_reg(pwmpt_pkg::REG_TIMER_CTRL, 8'h80);
        wait_irq();
        chk({15'h0000, irq}, 16'h0001);
        chk({15'h0000, mod_out}, 16'h0000);
        rd_chk(pwmpt_pkg::REG_IRQ_STAT, 8'h01);
        wr_reg(pwmpt_pkg::REG_IRQ_MASK, 8'h00);
        #1 chk({15'h0000, irq}, 16'h0000);
        wr_reg(pwmpt_pkg::REG_PIN_DIR, 8'h00);
        wr_reg(pwmpt_pkg::REG_PIN_ROUTE, 8'h01);
        wr_reg(pwmpt_pkg::REG_MOD_CTRL, 8'h80);
        measure(64);
        chk(hi, 16'h0018);
        chk(rise, 16'h0004);
        chk(hp, 16'h0018);
        chk({15'h0000, pin_oe_n}, 16'h0000);
        wr_reg(pwmpt_pkg::REG_MOD_CTRL, 8'h90);
        measure(64);
        chk(hi, 16'h0028);
        wr_reg(pwmpt_pkg::REG_MOD_CTRL, 8'h80);
        // a slower tick stretches period and pulse alike
        for (int s = 0; s < 3; s++) begin
            wr_reg(pwmpt_pkg::REG_TIMER_CTRL, 8'h80 | 8'(s));
            repeat (128) @(posedge clk);
            measure(256);
            chk(rise, 16'(16 >> s));
            chk(hi, 16'h0060);
        end
        wr_reg(pwmpt_pkg::REG_TIMER_CTRL, 8'h80);
        // short period: a pin that was not held would toggle inside the nap
        nap(16);
        chk({15'h0000, held}, 16'h0001);
        chk({8'h00, c1}, {8'h00, c0});
        // sleep again over a long period, where the count cannot wrap while awake
        wr_reg(pwmpt_pkg::REG_PERIOD, 8'hFF);
        wr_reg(pwmpt_pkg::REG_DUTY_H, 8'h80);
        wr_reg(pwmpt_pkg::REG_DUTY_L, 8'h00);
        repeat (300) @(posedge clk);
        nap(16);
        chk({15'h0000, held}, 16'h0001);
        chk({8'h00, c1}, {8'h00, c0});
        repeat (40) @(posedge clk);
        rd_reg(pwmpt_pkg::REG_TIMER_COUNT, c1);
        c1 = c1 - c0;
        chk({15'h0000, c1 >= 8'h09 && c1 <= 8'h0C}, 16'h0001);
        // one-clock pulse per period shows the finest step at each period value
        wr_reg(pwmpt_pkg::REG_DUTY_H, 8'h00);
        wr_reg(pwmpt_pkg::REG_DUTY_L, 8'h40);
        for (int r = 0; r < 3; r++) begin
            wr_reg(pwmpt_pkg::REG_PERIOD, RES_P[r]);
            repeat (1100) @(posedge clk);
            measure(1024);
            chk(hi, 16'(1024 / ((int'(RES_P[r]) + 1) * 4)));
            chk(rise, hi);
        end
        // turn the timer off first, or the flag sets again before it can be seen clear
        wr_reg(pwmpt_pkg::REG_TIMER_CTRL, 8'h00);
        wr_reg(pwmpt_pkg::REG_IRQ_STAT, 8'h01);
        rd_chk(pwmpt_pkg::REG_IRQ_STAT, 8'h00);
        wr_reg(pwmpt_pkg::REG_IRQ_MASK, 8'h01);
        #1 chk({15'h0000, irq}, 16'h0000);
        wr_reg(pwmpt_pkg::REG_PIN_ROUTE, 8'h00);
        wr_reg(pwmpt_pkg::REG_PORT, 8'h01);
        // pin data is registered behind the latch
        @(posedge clk);
        #1 chk({15'h0000, pin_o}, 16'h0001);
        wr_reg(pwmpt_pkg::REG_PORT, 8'h00);
        repeat (3) @(posedge clk);
        rd_chk(pwmpt_pkg::REG_PORT, 8'h00);
        wr_reg(pwmpt_pkg::REG_PIN_DIR, 8'h01);
        repeat (3) @(posedge clk);
        rd_chk(pwmpt_pkg::REG_PORT, 8'h01);
        wr_reg(pwmpt_pkg::REG_PIN_DIR, 8'h00);
        wr_reg(pwmpt_pkg::REG_TIMER_CTRL, 8'h80);
        wr_reg(pwmpt_pkg::REG_MOD_CTRL, 8'h80);
        repeat (20) @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1 chk({14'h0000, pin_oe_n, mod_out}, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        rd_chk(pwmpt_pkg::REG_PERIOD, 8'hFF);
        rd_chk(pwmpt_pkg::REG_MOD_CTRL, 8'h00);
        // enable already at the polarity step; output rises before the timer runs
        wr_reg(pwmpt_pkg::REG_MOD_CTRL, 8'h80);
        wr_reg(pwmpt_pkg::REG_PERIOD, 8'h03);
        wr_reg(pwmpt_pkg::REG_DUTY_H, 8'h01);
        wr_reg(pwmpt_pkg::REG_DUTY_L, 8'h80);
        wr_reg(pwmpt_pkg::REG_TIMER_CTRL, 8'h80);
        measure(64);
        chk(hi, 16'h0018);
        chk(rise, 16'h0004);
        results();
    end
endmodule

// file: testbench/pwmpt_load.sv
`timescale 1ns/100ps
module pwmpt_load (
    // pin from the device
    input  wire logic pin_o,
    input  wire logic pin_oe_n,
    // level seen on the wire
    output      logic pin_lvl
);
    // released pin floats up on the stage's pull-up, never to the last driven value
    assign pin_lvl = pin_oe_n ? 1'b1 : pin_o;
endmodule
